// ==== design/bridge_cmd_pkg.sv ====
// Constants shared by the bridge header and command register bank
package bridge_cmd_pkg;

	// ----------------------------------------------------------------
	// Configuration access geometry
	// ----------------------------------------------------------------
	localparam int CFG_AW = 12;
	localparam logic [11:0] CFG_OFS_VENDOR = 12'h000;
	localparam logic [11:0] CFG_OFS_DEVICE = 12'h002;
	localparam logic [11:0] CFG_OFS_COMMAND = 12'h004;
	localparam logic [11:0] CFG_OFS_STATUS = 12'h006;

	// ----------------------------------------------------------------
	// Command register fields
	// ----------------------------------------------------------------
	localparam int CMD_IO_BIT = 0;
	localparam int CMD_MEM_BIT = 1;
	localparam int CMD_FWD_BIT = 2;
	localparam int CMD_PAR_BIT = 6;
	localparam int CMD_ERR_BIT = 8;
	localparam int CMD_IRQ_BIT = 10;
	localparam logic [15:0] CMD_WR_MASK = 16'h0547;
	localparam logic [15:0] CMD_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Status register fields and sticky flag indices
	// ----------------------------------------------------------------
	localparam int STS_INT_BIT = 3;
	localparam int STS_CAPL_BIT = 4;
	localparam int STS_MDPE_BIT = 8;
	localparam int STS_SSE_BIT = 14;
	localparam int STS_DPE_BIT = 15;
	localparam int FLG_MDPE = 0;
	localparam int FLG_SSE = 1;
	localparam int FLG_DPE = 2;
	localparam int FLG_N = 3;

	// ----------------------------------------------------------------
	// Identity defaults (arbitrary values, not any maker's code)
	// ----------------------------------------------------------------
	localparam logic [15:0] VENDOR_IDENT_DEF = 16'h1a2b;
	localparam logic [15:0] DEVICE_IDENT_DEF = 16'h0001;

	typedef enum logic [1:0] {KIND_MEM, KIND_IO, KIND_MSG, KIND_CPL} req_kind_t;

endpackage

// ==== design/bridge_ctl_if.sv ====
// Carrier between the register core, the flag bank and the request gate
`timescale 1ns/10ps
interface bridge_ctl_if
	import bridge_cmd_pkg::*;
	();
	logic ce;
	logic [FLG_N-1:0] flag_set;
	logic [FLG_N-1:0] flag_clr;
	logic [FLG_N-1:0] flags;
	req_kind_t kind;
	logic nonposted;
	logic fwd_en;
	logic fwd;
	logic ur;
	modport flag_mp (input ce, input flag_set, input flag_clr,
		output flags);
	modport gate_mp (input kind, input nonposted, input fwd_en,
		output fwd, output ur);
	modport core_mp (output ce, output flag_set, output flag_clr,
		input flags, output kind, output nonposted, output fwd_en,
		input fwd, input ur);
endinterface

// ==== design/status_flag_bank.sv ====
// Sticky write-one-to-clear status flags, set wins over clear
`timescale 1ns/10ps
module status_flag_bank
	import bridge_cmd_pkg::*;
	(
	input wire logic clk_in,
	input wire logic rstn_in,
	bridge_ctl_if.flag_mp ctl
	);

	// ----------------------------------------------------------------
	// One flop per flag
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < FLG_N; i++)
		begin : g_flag
			logic flag_r;
			always_ff @(posedge clk_in)
			begin
				if (!rstn_in)
					flag_r <= 1'b0;
				else if (ctl.ce)
					flag_r <= (flag_r & ~ctl.flag_clr[i]) | ctl.flag_set[i];
			end
			assign ctl.flags[i] = flag_r;
		end
	endgenerate

endmodule

// ==== design/upstream_req_gate.sv ====
// Decides forwarding or Unsupported Request for secondary-side requests
`timescale 1ns/10ps
module upstream_req_gate
	import bridge_cmd_pkg::*;
	(
	bridge_ctl_if.gate_mp ctl
	);

	// ----------------------------------------------------------------
	// Gate
	// ----------------------------------------------------------------
	always_comb
	begin
		if (ctl.kind == KIND_MEM || ctl.kind == KIND_IO)
		begin
			ctl.fwd = ctl.fwd_en;
			ctl.ur = ~ctl.fwd_en & ctl.nonposted;
		end
		else
		begin
			// Messages and completions pass whatever the enable says
			ctl.fwd = 1'b1;
			ctl.ur = 1'b0;
		end
	end

endmodule

// ==== design/bridge_header_command_regs.sv ====
// Bridge header identity words, command register and command-gated paths
`timescale 1ns/10ps
module bridge_header_command_regs
	import bridge_cmd_pkg::*;
	#(
	parameter logic [15:0] VENDOR_IDENT = VENDOR_IDENT_DEF,
	parameter logic [15:0] DEVICE_IDENT = DEVICE_IDENT_DEF
	)
	(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// Configuration access port
	input wire logic cfg_req_in,
	input wire logic cfg_we_in,
	input wire logic [CFG_AW-1:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_ack_out,
	// Primary-side request decode
	input wire logic prim_valid_in,
	input wire logic io_window_hit_in,
	input wire logic mem_window_hit_in,
	input wire logic prefetch_window_hit_in,
	output logic prim_claim_out,
	// Secondary-side requests heading upstream
	input wire logic sec_valid_in,
	input wire req_kind_t sec_kind_in,
	input wire logic sec_nonposted_in,
	output logic sec_forward_out,
	output logic sec_ur_out,
	// Poisoned traffic on the primary side
	input wire logic poisoned_cpl_in,
	input wire logic poisoned_write_in,
	input wire logic poisoned_rx_in,
	// Own detected errors
	input wire logic own_fatal_in,
	input wire logic own_nonfatal_in,
	input wire logic devctl_fatal_en_in,
	input wire logic devctl_nonfatal_en_in,
	output logic err_fatal_msg_out,
	output logic err_nonfatal_msg_out,
	// Error messages arriving from the secondary side
	input wire logic sec_err_cor_in,
	input wire logic sec_err_nonfatal_in,
	input wire logic sec_err_fatal_in,
	output logic fwd_err_cor_out,
	output logic fwd_err_nonfatal_out,
	output logic fwd_err_fatal_out,
	// Legacy interrupts
	input wire logic own_irq_in,
	input wire logic [3:0] sec_intx_in,
	output logic intx_assert_out,
	output logic [3:0] intx_fwd_out
	);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	bridge_ctl_if ctl ();

	logic [15:0] command_r;
	logic [15:0] command_nxt;
	logic [15:0] status_view;
	logic [31:0] rdata_nxt;
	logic [9:0] cfg_dword;
	logic hit_ident;
	logic hit_cmd;
	logic wr_cmd;
	logic io_en;
	logic mem_en;
	logic fwd_en;
	logic par_en;
	logic err_en;
	logic irq_dis;
	logic own_fatal_send;
	logic own_nonfatal_send;
	logic any_err_sent;
	logic clr_lane;

	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------
	status_flag_bank u_flags (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ctl(ctl.flag_mp)
	);

	upstream_req_gate u_gate (
		.ctl(ctl.gate_mp)
	);

	// ----------------------------------------------------------------
	// Command field views
	// ----------------------------------------------------------------
	assign io_en = command_r[CMD_IO_BIT];
	assign mem_en = command_r[CMD_MEM_BIT];
	assign fwd_en = command_r[CMD_FWD_BIT];
	assign par_en = command_r[CMD_PAR_BIT];
	assign err_en = command_r[CMD_ERR_BIT];
	assign irq_dis = command_r[CMD_IRQ_BIT];

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Accesses are dword wide; byte enables pick the bytes
	assign cfg_dword = cfg_addr_in[CFG_AW-1:2];
	assign hit_ident = (cfg_dword == CFG_OFS_VENDOR[CFG_AW-1:2]);
	assign hit_cmd = (cfg_dword == CFG_OFS_COMMAND[CFG_AW-1:2]);
	assign wr_cmd = cfg_req_in & cfg_we_in & hit_cmd;

	// ----------------------------------------------------------------
	// Command register
	// ----------------------------------------------------------------
	always_comb
	begin
		command_nxt = command_r;
		if (wr_cmd && cfg_be_in[0])
			command_nxt[7:0] = cfg_wdata_in[7:0];
		if (wr_cmd && cfg_be_in[1])
			command_nxt[15:8] = cfg_wdata_in[15:8];
		// Hard-wired zero fields never take a written one
		command_nxt = command_nxt & CMD_WR_MASK;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			command_r <= CMD_RESET;
		else if (ce_in)
			command_r <= command_nxt;
	end

	// ----------------------------------------------------------------
	// Own error events and status flag sources
	// ----------------------------------------------------------------
	assign own_fatal_send = own_fatal_in & (err_en | devctl_fatal_en_in);
	assign own_nonfatal_send = own_nonfatal_in
		& (err_en | devctl_nonfatal_en_in);
	// Only messages sent under the command enable mark the status bit
	assign any_err_sent = err_en & (own_fatal_send | own_nonfatal_send
		| sec_err_fatal_in | sec_err_nonfatal_in);

	assign ctl.ce = ce_in;
	assign ctl.flag_set[FLG_MDPE] = par_en
		& (poisoned_cpl_in | poisoned_write_in);
	assign ctl.flag_set[FLG_SSE] = any_err_sent;
	assign ctl.flag_set[FLG_DPE] = poisoned_rx_in;

	// ----------------------------------------------------------------
	// Status flag clears
	// ----------------------------------------------------------------
	// Status bits 8, 14 and 15 all sit in the top byte lane
	// The bank lets a same-cycle set win, so a clear never drops an event
	assign clr_lane = wr_cmd & cfg_be_in[3];
	assign ctl.flag_clr[FLG_MDPE] = clr_lane
		& cfg_wdata_in[16+STS_MDPE_BIT];
	assign ctl.flag_clr[FLG_SSE] = clr_lane
		& cfg_wdata_in[16+STS_SSE_BIT];
	assign ctl.flag_clr[FLG_DPE] = clr_lane
		& cfg_wdata_in[16+STS_DPE_BIT];

	// ----------------------------------------------------------------
	// Status view
	// ----------------------------------------------------------------
	// Bit 3 is a live view and bit 4 is tied to one; unused bits read zero
	always_comb
	begin
		status_view = 16'h0000;
		status_view[STS_INT_BIT] = own_irq_in;
		status_view[STS_CAPL_BIT] = 1'b1;
		status_view[STS_MDPE_BIT] = ctl.flags[FLG_MDPE];
		status_view[STS_SSE_BIT] = ctl.flags[FLG_SSE];
		status_view[STS_DPE_BIT] = ctl.flags[FLG_DPE];
	end

	// ----------------------------------------------------------------
	// Configuration read data
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (hit_ident)
			rdata_nxt = {DEVICE_IDENT, VENDOR_IDENT};
		else if (hit_cmd)
			rdata_nxt = {status_view, command_r};
	end

	// Read data is zero outside its ack cycle, so a stale word is
	// never taken for an answer
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			cfg_rdata_out <= 32'h0000_0000;
		else if (ce_in)
			cfg_rdata_out <= (cfg_req_in && !cfg_we_in) ? rdata_nxt
				: 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// Configuration acknowledge
	// ----------------------------------------------------------------
	// Every request taken while ce_in is high, read or write, mapped or not, gets one ack
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			cfg_ack_out <= 1'b0;
		else if (ce_in)
			cfg_ack_out <= cfg_req_in;
	end

	// ----------------------------------------------------------------
	// Primary-side claim
	// ----------------------------------------------------------------
	// Window hits come from the decoders; only the enables are added
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			prim_claim_out <= 1'b0;
		else if (ce_in)
			prim_claim_out <= prim_valid_in
				& ((io_window_hit_in & io_en)
				| ((mem_window_hit_in | prefetch_window_hit_in)
				& mem_en));
	end

	// ----------------------------------------------------------------
	// Secondary-side request forwarding
	// ----------------------------------------------------------------
	assign ctl.kind = sec_kind_in;
	assign ctl.nonposted = sec_nonposted_in;
	assign ctl.fwd_en = fwd_en;

	// Both answers are registered; a non-posted request gets exactly one verdict
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			sec_forward_out <= 1'b0;
		else if (ce_in)
			sec_forward_out <= sec_valid_in & ctl.fwd;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			sec_ur_out <= 1'b0;
		else if (ce_in)
			sec_ur_out <= sec_valid_in & ctl.ur;
	end

	// ----------------------------------------------------------------
	// Own error messages
	// ----------------------------------------------------------------
	// Own messages go out under bit 8 or the matching device enable
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			err_fatal_msg_out <= 1'b0;
		else if (ce_in)
			err_fatal_msg_out <= own_fatal_send;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			err_nonfatal_msg_out <= 1'b0;
		else if (ce_in)
			err_nonfatal_msg_out <= own_nonfatal_send;
	end

	// ----------------------------------------------------------------
	// Forwarded error messages
	// ----------------------------------------------------------------
	// Correctable messages bypass the enable; the others need bit 8
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			fwd_err_cor_out <= 1'b0;
		else if (ce_in)
			fwd_err_cor_out <= sec_err_cor_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			fwd_err_nonfatal_out <= 1'b0;
		else if (ce_in)
			fwd_err_nonfatal_out <= sec_err_nonfatal_in & err_en;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			fwd_err_fatal_out <= 1'b0;
		else if (ce_in)
			fwd_err_fatal_out <= sec_err_fatal_in & err_en;
	end

	// ----------------------------------------------------------------
	// Legacy interrupts
	// ----------------------------------------------------------------
	// Setting the disable drops an asserted line, which a far-end
	// resolver sees as a deassertion
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			intx_assert_out <= 1'b0;
		else if (ce_in)
			intx_assert_out <= own_irq_in & ~irq_dis;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			intx_fwd_out <= 4'h0;
		else if (ce_in)
			intx_fwd_out <= sec_intx_in;
	end

endmodule

// ==== test/bridge_hdr_chk_sva.sv ====
// Port-level checker for the bridge header and command register bank
`timescale 1ns/10ps
module bridge_hdr_chk
	import bridge_cmd_pkg::*;
	(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic cfg_req_in,
	input wire logic cfg_ack_out,
	input wire logic prim_valid_in,
	input wire logic io_window_hit_in,
	input wire logic mem_window_hit_in,
	input wire logic prefetch_window_hit_in,
	input wire logic prim_claim_out,
	input wire logic sec_valid_in,
	input wire req_kind_t sec_kind_in,
	input wire logic sec_nonposted_in,
	input wire logic sec_forward_out,
	input wire logic sec_ur_out,
	input wire logic sec_err_cor_in,
	input wire logic fwd_err_cor_out,
	input wire logic own_irq_in,
	input wire logic intx_assert_out,
	input wire logic [3:0] sec_intx_in,
	input wire logic [3:0] intx_fwd_out
	);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	AST_ACK_NEXT: assert property (cfg_req_in && ce_in |=> cfg_ack_out)
		else $error("config access not acknowledged");
	AST_CLAIM_CAUSE: assert property (prim_claim_out |-> $past(prim_valid_in)
		&& $past(io_window_hit_in || mem_window_hit_in
		|| prefetch_window_hit_in))
		else $error("claim without a window hit");
	AST_NO_HIT: assert property (prim_valid_in && ce_in && !io_window_hit_in
		&& !mem_window_hit_in && !prefetch_window_hit_in
		|=> !prim_claim_out)
		else $error("claim outside every window");
	AST_MSG_CPL: assert property (sec_valid_in && ce_in
		&& sec_kind_in inside {KIND_MSG, KIND_CPL}
		|=> sec_forward_out && !sec_ur_out)
		else $error("message or completion not forwarded");
	AST_UR_CAUSE: assert property (sec_ur_out |-> $past(sec_valid_in)
		&& $past(sec_nonposted_in)
		&& $past(sec_kind_in) inside {KIND_MEM, KIND_IO})
		else $error("unsupported request without cause");
	AST_NP_ONE: assert property (sec_valid_in && ce_in && sec_nonposted_in
		&& sec_kind_in inside {KIND_MEM, KIND_IO}
		|=> sec_forward_out != sec_ur_out)
		else $error("non-posted request neither forwarded nor refused");
	AST_COR_FWD: assert property (sec_err_cor_in && ce_in |=> fwd_err_cor_out)
		else $error("correctable message dropped");
	AST_INTX_FWD: assert property (rstn_in && ce_in
		|=> intx_fwd_out == $past(sec_intx_in))
		else $error("forwarded interrupts differ");
	AST_IRQ_GATE: assert property (intx_assert_out |-> $past(own_irq_in))
		else $error("own interrupt asserted without cause");
endmodule

bind bridge_header_command_regs bridge_hdr_chk bridge_hdr_chk_i (
	.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
	.cfg_req_in(cfg_req_in), .cfg_ack_out(cfg_ack_out),
	.prim_valid_in(prim_valid_in), .io_window_hit_in(io_window_hit_in),
	.mem_window_hit_in(mem_window_hit_in),
	.prefetch_window_hit_in(prefetch_window_hit_in),
	.prim_claim_out(prim_claim_out), .sec_valid_in(sec_valid_in),
	.sec_kind_in(sec_kind_in), .sec_nonposted_in(sec_nonposted_in),
	.sec_forward_out(sec_forward_out), .sec_ur_out(sec_ur_out),
	.sec_err_cor_in(sec_err_cor_in), .fwd_err_cor_out(fwd_err_cor_out),
	.own_irq_in(own_irq_in), .intx_assert_out(intx_assert_out),
	.sec_intx_in(sec_intx_in), .intx_fwd_out(intx_fwd_out));

// ==== test/root_cfg_agent.sv ====
// Configuring agent model on the primary side issuing config accesses
`timescale 1ns/10ps
module root_cfg_agent
	import bridge_cmd_pkg::*;
	(
	input wire logic clk_in,
	input wire logic cfg_ack_in,
	input wire logic [31:0] cfg_rdata_in,
	output logic cfg_req_out,
	output logic cfg_we_out,
	output logic [CFG_AW-1:0] cfg_addr_out,
	output logic [3:0] cfg_be_out,
	output logic [31:0] cfg_wdata_out
	);
	initial
	begin
		cfg_req_out = 1'b0;
		cfg_we_out = 1'b0;
		cfg_addr_out = '0;
		cfg_be_out = 4'h0;
		cfg_wdata_out = 32'h0;
	end

	task automatic access(input logic we, input logic [CFG_AW-1:0] addr,
		input logic [3:0] be, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic ok);
		int i;
		@(posedge clk_in);
		cfg_req_out <= 1'b1;
		cfg_we_out <= we;
		cfg_addr_out <= addr;
		cfg_be_out <= be;
		cfg_wdata_out <= wdata;
		@(posedge clk_in);
		// Address and write data flip so a stale value is never mistaken for data
		cfg_req_out <= 1'b0;
		cfg_addr_out <= ~addr;
		cfg_wdata_out <= ~wdata;
		ok = 1'b0;
		rdata = 32'hx;
		for (i = 0; i < 4 && !ok; i++)
		begin
			#1;
			ok = (cfg_ack_in === 1'b1);
			rdata = cfg_rdata_in;
			if (!ok)
				@(posedge clk_in);
		end
	endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the bridge header and command register bank
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	import bridge_cmd_pkg::*;
	// Arbitrary identity values, unrelated to any maker
	localparam logic [15:0] vend_id = 16'h5a5a;
	localparam logic [15:0] dev_id = 16'h0c3e;
	typedef struct packed {logic [15:0] cmd; logic [2:0] hits;
		req_kind_t kind; logic np; logic [2:0] res;} row_t;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cfg_req_in, cfg_we_in, cfg_ack_out, ok;
	logic [CFG_AW-1:0] cfg_addr_in;
	logic [3:0] cfg_be_in, sec_intx_in = 4'h0, intx_fwd_out;
	logic [31:0] cfg_wdata_in, cfg_rdata_out, rd;
	logic io_window_hit_in = 1'b0, mem_window_hit_in = 1'b0;
	logic prefetch_window_hit_in = 1'b0, sec_nonposted_in = 1'b0;
	req_kind_t sec_kind_in = KIND_MEM;
	logic devctl_fatal_en_in = 1'b0, devctl_nonfatal_en_in = 1'b0;
	logic own_irq_in = 1'b0, intx_assert_out, ce_in = 1'b1;
	logic prim_valid_in, sec_valid_in, poisoned_cpl_in, poisoned_write_in;
	logic own_fatal_in, own_nonfatal_in, sec_err_cor_in;
	logic sec_err_nonfatal_in, sec_err_fatal_in;
	logic prim_claim_out, sec_forward_out, sec_ur_out, err_fatal_msg_out;
	logic err_nonfatal_msg_out, fwd_err_cor_out, fwd_err_nonfatal_out;
	logic fwd_err_fatal_out;
	logic [8:0] ev = 9'h0;
	logic [7:0] outs;
	int n_errors = 0;
	int checked = 0;
	// Events: prim sec pcpl pwr ofat onf cor snf sfat
	assign {prim_valid_in, sec_valid_in, poisoned_cpl_in, poisoned_write_in,
		own_fatal_in, own_nonfatal_in, sec_err_cor_in, sec_err_nonfatal_in,
		sec_err_fatal_in} = ev;
	// Outputs: claim fwd ur efat enf cor snf sfat
	assign outs = {prim_claim_out, sec_forward_out, sec_ur_out,
		err_fatal_msg_out, err_nonfatal_msg_out, fwd_err_cor_out,
		fwd_err_nonfatal_out, fwd_err_fatal_out};
	row_t rows [10] = '{
		'{16'h0000, 3'b100, KIND_MEM, 1'b1, 3'b001},
		'{16'h0001, 3'b100, KIND_IO, 1'b1, 3'b101},
		'{16'h0002, 3'b010, KIND_MEM, 1'b0, 3'b100},
		'{16'h0002, 3'b001, KIND_IO, 1'b0, 3'b100},
		'{16'h0005, 3'b100, KIND_MSG, 1'b1, 3'b110},
		'{16'h0004, 3'b000, KIND_MEM, 1'b1, 3'b010},
		'{16'h0004, 3'b001, KIND_CPL, 1'b1, 3'b010},
		'{16'h0006, 3'b001, KIND_IO, 1'b1, 3'b110},
		'{16'h0000, 3'b000, KIND_MSG, 1'b0, 3'b010},
		'{16'h0000, 3'b100, KIND_CPL, 1'b1, 3'b010}};

	always #5 clk_in = ~clk_in;

	bridge_header_command_regs #(.VENDOR_IDENT(vend_id),
		.DEVICE_IDENT(dev_id)) bridge_header_command_regs_i (
		.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
		.cfg_req_in(cfg_req_in), .cfg_we_in(cfg_we_in),
		.cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in),
		.cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
		.cfg_ack_out(cfg_ack_out), .prim_valid_in(prim_valid_in),
		.io_window_hit_in(io_window_hit_in),
		.mem_window_hit_in(mem_window_hit_in),
		.prefetch_window_hit_in(prefetch_window_hit_in),
		.prim_claim_out(prim_claim_out), .sec_valid_in(sec_valid_in),
		.sec_kind_in(sec_kind_in), .sec_nonposted_in(sec_nonposted_in),
		.sec_forward_out(sec_forward_out), .sec_ur_out(sec_ur_out),
		.poisoned_cpl_in(poisoned_cpl_in),
		.poisoned_write_in(poisoned_write_in), .poisoned_rx_in(1'b0),
		.own_fatal_in(own_fatal_in), .own_nonfatal_in(own_nonfatal_in),
		.devctl_fatal_en_in(devctl_fatal_en_in),
		.devctl_nonfatal_en_in(devctl_nonfatal_en_in),
		.err_fatal_msg_out(err_fatal_msg_out),
		.err_nonfatal_msg_out(err_nonfatal_msg_out),
		.sec_err_cor_in(sec_err_cor_in),
		.sec_err_nonfatal_in(sec_err_nonfatal_in),
		.sec_err_fatal_in(sec_err_fatal_in),
		.fwd_err_cor_out(fwd_err_cor_out),
		.fwd_err_nonfatal_out(fwd_err_nonfatal_out),
		.fwd_err_fatal_out(fwd_err_fatal_out), .own_irq_in(own_irq_in),
		.sec_intx_in(sec_intx_in), .intx_assert_out(intx_assert_out),
		.intx_fwd_out(intx_fwd_out));

	root_cfg_agent root_cfg_agent_i (.clk_in(clk_in),
		.cfg_ack_in(cfg_ack_out), .cfg_rdata_in(cfg_rdata_out),
		.cfg_req_out(cfg_req_in), .cfg_we_out(cfg_we_in),
		.cfg_addr_out(cfg_addr_in), .cfg_be_out(cfg_be_in),
		.cfg_wdata_out(cfg_wdata_in));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A missing acknowledge ends the run at once
	task automatic cfg(input logic we, input logic [CFG_AW-1:0] a,
		input logic [3:0] be, input logic [31:0] d);
		root_cfg_agent_i.access(we, a, be, d, rd, ok);
		`CHK(ok, 1'b1)
		if (ok !== 1'b1)
			final_report();
	endtask

	task automatic pulse(input logic [8:0] e, input logic [7:0] exp_o);
		@(posedge clk_in);
		ev <= e;
		@(posedge clk_in);
		ev <= 9'h0;
		#1;
		`CHK(outs, exp_o)
	endtask

	initial
	begin
		repeat (16) @(posedge clk_in);
		rstn_in <= 1'b1;
		// --------------------------------------------------------
		// Table of decode and forwarding cases
		// --------------------------------------------------------
		foreach (rows[i])
		begin
			cfg(1'b1, CFG_OFS_COMMAND, 4'b0011, {16'h0, rows[i].cmd});
			@(posedge clk_in);
			{io_window_hit_in, mem_window_hit_in,
				prefetch_window_hit_in} <= rows[i].hits;
			sec_kind_in <= rows[i].kind;
			sec_nonposted_in <= rows[i].np;
			pulse(9'h180, {rows[i].res, 5'h0});
		end
		$display("test decode table done");
		// --------------------------------------------------------
		// Identity words and read-only fields
		// --------------------------------------------------------
		cfg(1'b0, CFG_OFS_VENDOR, 4'hf, 32'h0);
		`CHK(rd, {dev_id, vend_id})
		cfg(1'b1, CFG_OFS_VENDOR, 4'hf, 32'hffff_ffff);
		cfg(1'b0, CFG_OFS_DEVICE, 4'hf, 32'h0);
		`CHK(rd, {dev_id, vend_id})
		cfg(1'b1, CFG_OFS_COMMAND, 4'b0011, 32'h0000_ffff);
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0010_0547)
		cfg(1'b1, 12'h100, 4'hf, 32'hffff_ffff);
		cfg(1'b0, 12'h100, 4'hf, 32'h0);
		`CHK(rd, 32'h0)
		$display("test read-only fields done");
		// --------------------------------------------------------
		// Error reporting and forwarding
		// --------------------------------------------------------
		cfg(1'b1, CFG_OFS_COMMAND, 4'b0011, 32'h0);
		pulse(9'h01f, 8'h04);
		@(posedge clk_in);
		devctl_fatal_en_in <= 1'b1;
		pulse(9'h018, 8'h10);
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0010_0000)
		cfg(1'b1, CFG_OFS_COMMAND, 4'b0011, 32'h0000_0100);
		pulse(9'h007, 8'h07);
		pulse(9'h008, 8'h08);
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h4010_0100)
		cfg(1'b1, CFG_OFS_COMMAND, 4'b1000, 32'h4000_0000);
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0010_0100)
		$display("test error signalling done");
		// --------------------------------------------------------
		// Poisoned traffic and the parity flag
		// --------------------------------------------------------
		pulse(9'h060, 8'h00);
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0010_0100)
		cfg(1'b1, CFG_OFS_COMMAND, 4'b0011, 32'h0000_0140);
		pulse(9'h020, 8'h00);
		cfg(1'b1, CFG_OFS_COMMAND, 4'b1000, 32'h0);
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0110_0140)
		cfg(1'b1, CFG_OFS_COMMAND, 4'b1000, 32'h0100_0000);
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0010_0140)
		$display("test parity flag done");
		// --------------------------------------------------------
		// Clock enable low freezes every strobe
		// --------------------------------------------------------
		@(posedge clk_in);
		ce_in <= 1'b0;
		ev <= 9'h004;
		repeat (2) @(posedge clk_in);
		ce_in <= 1'b1;
		#1;
		`CHK(outs, 8'h00)
		@(posedge clk_in);
		ev <= 9'h0;
		#1;
		`CHK(outs, 8'h04)
		$display("test clock enable done");
		// --------------------------------------------------------
		// Legacy interrupts, then a reset in mid-run
		// --------------------------------------------------------
		@(posedge clk_in);
		own_irq_in <= 1'b1;
		sec_intx_in <= 4'ha;
		repeat (2) @(posedge clk_in);
		#1;
		`CHK({intx_assert_out, intx_fwd_out}, 5'h1a)
		cfg(1'b1, CFG_OFS_COMMAND, 4'b0011, 32'h0000_0540);
		#10;
		`CHK({intx_assert_out, intx_fwd_out}, 5'h0a)
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0018_0540)
		@(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		cfg(1'b0, CFG_OFS_COMMAND, 4'hf, 32'h0);
		`CHK(rd, 32'h0018_0000)
		$display("test interrupts and reset done");
		final_report();
	end
endmodule
